// ---- rtl/bcs_pkg.sv ----
/*
  Shared constants and types of the breaker command sequencer: register map,
  setting limits and defaults, timer slots and packed carriers.
  Assumes a 100 MHz pclk and an APB master with 32-bit data.
*/
package bcs_pkg;

  // ***********************************************
  // Time base
  // ***********************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

  // ***********************************************
  // Register map
  // ***********************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_PULSE = 8'h08;
  localparam logic [7:0] REG_OPER = 8'h0C;
  localparam logic [7:0] REG_INTER = 8'h10;
  localparam logic [7:0] REG_SYNC = 8'h14;
  localparam logic [7:0] REG_SWITCH = 8'h18;
  localparam logic [7:0] REG_SBO = 8'h1C;
  localparam logic [7:0] REG_STATUS = 8'h20;
  localparam logic [7:0] REG_COUNT = 8'h24;

  // ***********************************************
  // Settings in ms: default, minimum, maximum
  // ***********************************************
  localparam int LIM_W = 16;
  localparam logic [15:0] PULSE_DEF = 16'h012C;
  localparam logic [15:0] PULSE_MIN = 16'h0032;
  localparam logic [15:0] PULSE_MAX = 16'h03E8;
  localparam logic [15:0] OPER_DEF = 16'h00C8;
  localparam logic [15:0] OPER_MIN = 16'h000A;
  localparam logic [15:0] OPER_MAX = 16'h03E8;
  localparam logic [15:0] INTER_DEF = 16'h0064;
  localparam logic [15:0] INTER_MIN = 16'h0014;
  localparam logic [15:0] INTER_MAX = 16'h01F4;
  localparam logic [15:0] SYNC_DEF = 16'h03E8;
  localparam logic [15:0] SYNC_MIN = 16'h000A;
  localparam logic [15:0] SYNC_MAX = 16'h1388;
  localparam logic [15:0] SWITCH_DEF = 16'h0000;
  localparam logic [15:0] SWITCH_MIN = 16'h0000;
  localparam logic [15:0] SWITCH_MAX = 16'hEA60;
  localparam logic [15:0] SBO_DEF = 16'h1388;
  localparam logic [15:0] SBO_MIN = 16'h03E8;
  localparam logic [15:0] SBO_MAX = 16'h4E20;
  localparam logic [15:0] MIN_PULSE_MS = 16'h0064;
  localparam logic [15:0] OP_PULSE_MS = 16'h0096;
  localparam logic FORCED_CHECK_DEF = 1'b1;

  // ***********************************************
  // Breaker state codes
  // ***********************************************
  localparam logic [1:0] POS_INTER = 2'h0;
  localparam logic [1:0] POS_OFF = 2'h1;
  localparam logic [1:0] POS_ON = 2'h2;

  // ***********************************************
  // Timer slots
  // ***********************************************
  localparam int NUM_TIMERS = 5;
  localparam int T_PULSE = 0;
  localparam int T_OPER = 1;
  localparam int T_INTER = 2;
  localparam int T_WAIT = 3;
  localparam int T_OPP = 4;
  localparam int COUNT_W = 32;

  typedef enum logic [1:0] {
    MODEL_DIRECT_NORMAL,
    MODEL_DIRECT_ENHANCED,
    MODEL_SBO_ENHANCED
  } bcs_model_t;

  // Command word, bit 0 is open
  localparam int CMD_W = 5;
  typedef struct packed {
    logic skip_check;
    logic panel;
    logic select;
    logic close;
    logic open;
  } bcs_cmd_t;

  typedef struct packed {
    logic rejected;
    logic invalid_position;
    logic intermediate;
    logic unintended;
    logic op_pulse;
    logic selected;
    logic busy;
    logic sync_start;
    logic close_out;
    logic open_out;
    logic [1:0] code;
  } bcs_status_t;

  typedef struct packed {
    logic [15:0] pulse;
    logic [15:0] oper;
    logic [15:0] inter;
    logic [15:0] sync;
    logic [15:0] sw;
    logic [15:0] sbo;
  } bcs_limits_t;

endpackage : bcs_pkg

// ---- rtl/bcs_timer_bank.sv ----
/*
  Bank of millisecond up-counters, one per timer slot.
  Assumes a one-cycle ms_tick pulse on pclk; counts saturate.
*/
`timescale 1ns/1ns
module bcs_timer_bank import bcs_pkg::*; #(
  parameter int N = NUM_TIMERS,
  parameter int W = LIM_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ms_tick,
  input wire logic [N-1:0] restart,
  output logic [N-1:0][W-1:0] count
);

  for (genvar i = 0; i < N; i++) begin : g_tmr
    logic [W-1:0] cnt;
    // Restart has priority over counting
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt <= '0;
      end else if (restart[i]) begin
        cnt <= '0;
      end else if (ms_tick && cnt != {W{1'b1}}) begin
        cnt <= cnt + 1'b1;
      end
    end
    assign count[i] = cnt;
  end

endmodule : bcs_timer_bank

// ---- rtl/bcs_breaker_sequencer.sv ----
/*
  Breaker command sequencer: APB settings and commands, permission and
  interlock gating, control models, timed open/close pulses, position supervision.
  Assumes inputs synchronous to pclk; pclk 100 MHz; presetn asynchronous.
*/
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
module bcs_breaker_sequencer import bcs_pkg::*; #(
  parameter int TICK_DIV = TICK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic panel_permit_in,
  input wire logic master_permit_in,
  input wire logic synchronism_ok_in,
  input wire logic open_interlock_permit,
  input wire logic close_interlock_permit,
  input wire logic block_operation_in,
  input wire logic position_open_in,
  input wire logic position_closed_in,
  input wire logic external_command_seen,
  input wire logic synchro_switch_impulse_in,
  output logic open_cmd_out,
  output logic close_cmd_out,
  output logic synchro_switch_start_out,
  output logic unintended_operation_out,
  output logic intermediate_out,
  output logic operation_pulse_out,
  output logic invalid_position_out,
  output logic [1:0] breaker_state_code
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_SELECTED, ST_SYNC_WAIT, ST_SWITCH_WAIT, ST_PULSE, ST_CONFIRM
  } bcs_state_t;

  bcs_state_t state, next_state;
  bcs_limits_t lim;
  bcs_model_t control_model_select;
  logic forced_check;
  logic [31:0] div_cnt;
  logic ms_tick;
  logic dir_close, dir_panel, chk_on, oper_armed, cmd_pending;
  logic rejected_flag, invalid_flag;
  logic [1:0] last_end;
  logic [COUNT_W-1:0] operation_count;
  logic [NUM_TIMERS-1:0] t_restart;
  logic [NUM_TIMERS-1:0][LIM_W-1:0] t_cnt;

  function automatic logic [15:0] clamp(input logic [31:0] v, input logic [15:0] lo,
                                        input logic [15:0] hi);
    if (v < {16'h0000, lo}) return lo;
    if (v > {16'h0000, hi}) return hi;
    return v[15:0];
  endfunction : clamp

  // ***********************************************
  // Millisecond tick
  // ***********************************************
  wire logic div_end = (div_cnt == 32'(TICK_DIV - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 32'h0;
      ms_tick <= 1'b0;
    end else begin
      div_cnt <= div_end ? 32'h0 : div_cnt + 32'h1;
      ms_tick <= div_end;
    end
  end

  bcs_timer_bank #(.N(NUM_TIMERS), .W(LIM_W)) u_timers (
    .pclk(pclk),
    .presetn(presetn),
    .ms_tick(ms_tick),
    .restart(t_restart),
    .count(t_cnt)
  );

  // ***********************************************
  // APB slave, one wait state
  // ***********************************************
  wire logic apb_access = psel && penable && !pready;
  wire logic apb_done = psel && penable && pready;
  wire logic wr_en = apb_done && pwrite;
  wire logic addr_hit = (paddr == REG_CTRL) || (paddr == REG_CMD) || (paddr == REG_PULSE)
                     || (paddr == REG_OPER) || (paddr == REG_INTER) || (paddr == REG_SYNC)
                     || (paddr == REG_SWITCH) || (paddr == REG_SBO)
                     || (paddr == REG_STATUS) || (paddr == REG_COUNT);
  bcs_status_t status;
  assign status = '{rejected: rejected_flag, invalid_position: invalid_flag,
                    intermediate: intermediate_out, unintended: unintended_operation_out,
                    op_pulse: operation_pulse_out, selected: state == ST_SELECTED,
                    busy: state != ST_IDLE, sync_start: synchro_switch_start_out,
                    close_out: close_cmd_out, open_out: open_cmd_out,
                    code: breaker_state_code};
  wire logic [31:0] rd_data =
      (paddr == REG_CTRL) ? {29'h0, forced_check, control_model_select} :
      (paddr == REG_PULSE) ? {16'h0, lim.pulse} :
      (paddr == REG_OPER) ? {16'h0, lim.oper} :
      (paddr == REG_INTER) ? {16'h0, lim.inter} :
      (paddr == REG_SYNC) ? {16'h0, lim.sync} :
      (paddr == REG_SWITCH) ? {16'h0, lim.sw} :
      (paddr == REG_SBO) ? {16'h0, lim.sbo} :
      (paddr == REG_STATUS) ? 32'(status) :
      (paddr == REG_COUNT) ? 32'(operation_count) : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= apb_access;
      pslverr <= apb_access && !addr_hit;
      prdata <= (apb_access && !pwrite) ? rd_data : 32'h0;
    end
  end

  wire logic wr_ctrl = wr_en && paddr == REG_CTRL;
  wire logic model_ok = pwdata[1:0] != 2'h3;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_model_select <= MODEL_DIRECT_NORMAL;
      forced_check <= FORCED_CHECK_DEF;
      lim <= '{pulse: PULSE_DEF, oper: OPER_DEF, inter: INTER_DEF, sync: SYNC_DEF,
               sw: SWITCH_DEF, sbo: SBO_DEF};
    end else if (wr_en) begin
      if (wr_ctrl && model_ok) control_model_select <= bcs_model_t'(pwdata[1:0]);
      if (wr_ctrl) forced_check <= pwdata[2];
      if (paddr == REG_PULSE) lim.pulse <= clamp(pwdata, PULSE_MIN, PULSE_MAX);
      if (paddr == REG_OPER) lim.oper <= clamp(pwdata, OPER_MIN, OPER_MAX);
      if (paddr == REG_INTER) lim.inter <= clamp(pwdata, INTER_MIN, INTER_MAX);
      if (paddr == REG_SYNC) lim.sync <= clamp(pwdata, SYNC_MIN, SYNC_MAX);
      if (paddr == REG_SWITCH) lim.sw <= clamp(pwdata, SWITCH_MIN, SWITCH_MAX);
      if (paddr == REG_SBO) lim.sbo <= clamp(pwdata, SBO_MIN, SBO_MAX);
    end
  end

  // ***********************************************
  // Command gating
  // ***********************************************
  bcs_cmd_t cmd;
  assign cmd = bcs_cmd_t'(pwdata[CMD_W-1:0]);
  wire logic cmd_strobe = wr_en && paddr == REG_CMD;
  wire logic sbo = control_model_select == MODEL_SBO_ENHANCED;
  wire logic enhanced = control_model_select != MODEL_DIRECT_NORMAL;
  wire logic src_ok = cmd.panel ? panel_permit_in : master_permit_in;
  wire logic from_idle = state == ST_IDLE && cmd.select == sbo;
  wire logic from_sel = state == ST_SELECTED && !cmd.select && cmd.close == dir_close
                     && cmd.panel == dir_panel;
  wire logic accept = cmd_strobe && (cmd.open ^ cmd.close) && src_ok && !block_operation_in
                   && (from_idle || from_sel);
  wire logic go_req = accept && !(state == ST_IDLE && sbo);
  wire logic go_chk = forced_check || !cmd.skip_check;
  wire logic go_lock = !go_chk || (cmd.close ? close_interlock_permit
                                              : open_interlock_permit);
  wire logic go_sync = !cmd.close || !go_chk || synchronism_ok_in;
  wire logic reject_ev = cmd_strobe && !(accept && (!go_req || go_lock));
  wire logic held_lock = !chk_on || close_interlock_permit;

  // ***********************************************
  // Position supervision
  // ***********************************************
  wire logic end_pos = breaker_state_code == POS_OFF || breaker_state_code == POS_ON;
  wire logic op_event = end_pos && last_end != POS_INTER && breaker_state_code != last_end;
  wire logic reached = breaker_state_code == (dir_close ? POS_ON : POS_OFF);
  wire logic pulse_done = t_cnt[T_PULSE] >= lim.pulse
                       || (reached && t_cnt[T_PULSE] >= MIN_PULSE_MS);
  wire logic inval_fire = oper_armed && !reached && t_cnt[T_OPER] >= lim.oper;

  // ***********************************************
  // Sequencer
  // ***********************************************
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE, ST_SELECTED: begin
        if (accept && !go_req) begin
          next_state = ST_SELECTED;
        end else if (go_req && go_lock) begin
          next_state = go_sync ? ST_PULSE : ST_SYNC_WAIT;
        end else if (state == ST_SELECTED && t_cnt[T_WAIT] >= lim.sbo) begin
          next_state = ST_IDLE;
        end
      end
      ST_SYNC_WAIT: begin
        if (block_operation_in) begin
          next_state = ST_IDLE;
        end else if (synchronism_ok_in && held_lock) begin
          next_state = ST_PULSE;
        end else if (t_cnt[T_WAIT] >= lim.sync) begin
          next_state = (lim.sw == 16'h0000) ? ST_IDLE : ST_SWITCH_WAIT;
        end
      end
      ST_SWITCH_WAIT: begin
        if (block_operation_in) begin
          next_state = ST_IDLE;
        end else if (synchro_switch_impulse_in && held_lock) begin
          next_state = ST_PULSE;
        end else if (t_cnt[T_WAIT] >= lim.sw) begin
          next_state = ST_IDLE;
        end
      end
      ST_PULSE: begin
        if (block_operation_in || pulse_done) begin
          next_state = (oper_armed && !reached) ? ST_CONFIRM : ST_IDLE;
        end
      end
      ST_CONFIRM: begin
        if (reached || inval_fire || !oper_armed) next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  wire logic enter_pulse = next_state == ST_PULSE && state != ST_PULSE;
  wire logic load_cmd = accept && (state == ST_IDLE || go_req);
  wire logic next_dir_close = (accept && state == ST_IDLE) ? cmd.close : dir_close;

  assign t_restart[T_PULSE] = enter_pulse;
  assign t_restart[T_OPER] = enter_pulse;
  assign t_restart[T_INTER] = breaker_state_code != POS_INTER;
  assign t_restart[T_WAIT] = next_state != state;
  assign t_restart[T_OPP] = op_event;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      dir_close <= 1'b0;
      dir_panel <= 1'b0;
      chk_on <= 1'b1;
    end else begin
      state <= next_state;
      dir_close <= next_dir_close;
      if (accept && state == ST_IDLE) dir_panel <= cmd.panel;
      if (load_cmd) chk_on <= go_chk;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      open_cmd_out <= 1'b0;
      close_cmd_out <= 1'b0;
      synchro_switch_start_out <= 1'b0;
      oper_armed <= 1'b0;
      invalid_position_out <= 1'b0;
    end else begin
      open_cmd_out <= next_state == ST_PULSE && !next_dir_close;
      close_cmd_out <= next_state == ST_PULSE && next_dir_close;
      synchro_switch_start_out <= next_state == ST_SWITCH_WAIT;
      invalid_position_out <= inval_fire;
      if (enter_pulse) oper_armed <= enhanced;
      else if (reached || inval_fire) oper_armed <= 1'b0;
    end
  end

  // ***********************************************
  // Position state, operation and flags
  // ***********************************************
  wire logic clr_status = wr_en && paddr == REG_STATUS;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      breaker_state_code <= POS_INTER;
      last_end <= POS_INTER;
      intermediate_out <= 1'b0;
      operation_pulse_out <= 1'b0;
      operation_count <= '0;
      cmd_pending <= 1'b0;
      unintended_operation_out <= 1'b0;
      rejected_flag <= 1'b0;
      invalid_flag <= 1'b0;
    end else begin
      breaker_state_code <= {position_closed_in, position_open_in};
      if (end_pos) last_end <= breaker_state_code;
      intermediate_out <= breaker_state_code == POS_INTER
                       && t_cnt[T_INTER] > lim.inter;
      operation_pulse_out <= op_event
                          || (operation_pulse_out && t_cnt[T_OPP] < OP_PULSE_MS);
      if (op_event) operation_count <= operation_count + 1'b1;
      cmd_pending <= enter_pulse || (cmd_pending && !op_event);
      unintended_operation_out <= (op_event && !cmd_pending && !external_command_seen)
                               || (unintended_operation_out && !enter_pulse);
      rejected_flag <= reject_ev || (rejected_flag && !(clr_status && pwdata[11]));
      invalid_flag <= inval_fire || (invalid_flag && !(clr_status && pwdata[10]));
    end
  end

  // ***********************************************
  // Checks
  // ***********************************************
  chk_panel_permit: assert property (@(posedge pclk) disable iff (!presetn)
    accept && cmd.panel |-> panel_permit_in) else $error("panel command without permission");
  chk_master_permit: assert property (@(posedge pclk) disable iff (!presetn)
    accept && !cmd.panel |-> master_permit_in) else $error("master command without permit");
  chk_close_sync: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(close_cmd_out) && $past(state) == ST_SYNC_WAIT |-> $past(synchronism_ok_in))
    else $error("close left sync wait without synchronism");
  chk_open_lock: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(open_cmd_out) && chk_on |-> $past(open_interlock_permit))
    else $error("open issued against interlock");
  chk_block_stop: assert property (@(posedge pclk) disable iff (!presetn)
    block_operation_in |=> !$rose(open_cmd_out) && !$rose(close_cmd_out))
    else $error("switching started while blocked");
  chk_pulse_max: assert property (@(posedge pclk) disable iff (!presetn)
    open_cmd_out || close_cmd_out |-> t_cnt[T_PULSE] <= lim.pulse)
    else $error("command pulse overran its duration");
  chk_pulse_min: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(open_cmd_out) && !$past(block_operation_in) |-> $past(t_cnt[T_PULSE]) >= MIN_PULSE_MS
    || $past(t_cnt[T_PULSE]) >= $past(lim.pulse))
    else $error("command pulse shorter than minimum");
  chk_switch_zero: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(synchro_switch_start_out) |-> $past(lim.sw) != 16'h0000)
    else $error("synchro switch start with zero time");
  chk_state_code: assert property (@(posedge pclk) disable iff (!presetn)
    $past(presetn) |-> breaker_state_code == $past({position_closed_in, position_open_in}))
    else $error("state code does not follow positions");
  chk_busy_reject: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_strobe && state inside {ST_PULSE, ST_CONFIRM, ST_SYNC_WAIT} |=> rejected_flag)
    else $error("command taken while busy");
  chk_op_count: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(operation_pulse_out) |-> operation_count == $past(operation_count) + 1'b1)
    else $error("operation counter did not follow pulse");

  cov_sync_close: cover property (@(posedge pclk) disable iff (!presetn)
    state == ST_SYNC_WAIT ##1 state == ST_PULSE);
  cov_sbo_operate: cover property (@(posedge pclk) disable iff (!presetn)
    state == ST_SELECTED ##1 state == ST_PULSE);
  cov_unintended: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(unintended_operation_out));
  cov_invalid: cover property (@(posedge pclk) disable iff (!presetn)
    invalid_position_out);

endmodule : bcs_breaker_sequencer

// ---- verif/bcs_breaker_model.sv ----
/*
  Breaker auxiliary contacts moving to the commanded end position.
  Assumes sequencer command outputs; travel 0 is a stuck breaker.
*/
`timescale 1ns/1ns
module bcs_breaker_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic open_cmd_out,
  input wire logic close_cmd_out,
  input wire logic kick,
  input wire logic [7:0] travel,
  output logic position_open_in,
  output logic position_closed_in
);
  logic [7:0] cnt;
  logic was;
  logic to_on;
  wire logic go = ((open_cmd_out | close_cmd_out) & !was) | kick;
  // ****
  // Both contacts drop while moving
  // ****
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 8'h00;
      was <= 1'b0;
      to_on <= 1'b0;
      position_open_in <= 1'b1;
      position_closed_in <= 1'b0;
    end else begin
      was <= open_cmd_out | close_cmd_out;
      if (go && cnt == 8'h00 && travel != 8'h00) begin
        cnt <= travel;
        to_on <= kick ? position_open_in : close_cmd_out;
        position_open_in <= 1'b0;
        position_closed_in <= 1'b0;
      end else if (cnt == 8'h01) begin
        cnt <= 8'h00;
        position_open_in <= !to_on;
        position_closed_in <= to_on;
      end else if (cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
      end
    end
  end
endmodule : bcs_breaker_model

// ---- verif/breaker_command_sequencer_test.sv ----
/*
  Self-checking bench of the breaker command sequencer.
  Assumes a 1 ms tick of ten pclk cycles and the contact model.
*/
`timescale 1ns/1ns
module breaker_command_sequencer_test import bcs_pkg::*;;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err, pready, pslverr;
  logic [7:0] paddr = 8'h00, travel = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, r, c0;
  logic panel_permit_in = 0, master_permit_in = 0, synchronism_ok_in = 1, kick = 0;
  logic open_interlock_permit = 1, close_interlock_permit = 1, block_operation_in = 0;
  logic external_command_seen = 0, synchro_switch_impulse_in = 0, seen_start = 0, seen_inval = 0;
  logic position_open_in, position_closed_in, open_cmd_out, close_cmd_out;
  logic synchro_switch_start_out, unintended_operation_out, intermediate_out;
  logic operation_pulse_out, invalid_position_out;
  logic [1:0] breaker_state_code;
  logic [15:0] dflt [6] = '{PULSE_DEF, OPER_DEF, INTER_DEF, SYNC_DEF, SWITCH_DEF, SBO_DEF};
  int num_errors = 0, n_checks = 0, cycles = 0, run = 0, last = 0, seed = 10619;
  bcs_breaker_sequencer #(.TICK_DIV(10)) i_bcs_breaker_sequencer (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .panel_permit_in, .master_permit_in, .synchronism_ok_in, .open_interlock_permit,
    .close_interlock_permit, .block_operation_in, .position_open_in, .position_closed_in,
    .external_command_seen, .synchro_switch_impulse_in, .open_cmd_out, .close_cmd_out,
    .synchro_switch_start_out, .unintended_operation_out, .intermediate_out,
    .operation_pulse_out, .invalid_position_out, .breaker_state_code);
  bcs_breaker_model i_bcs_breaker_model (.pclk, .presetn, .open_cmd_out, .close_cmd_out,
    .kick, .travel, .position_open_in, .position_closed_in);
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (synchro_switch_start_out) seen_start <= 1'b1;
    if (invalid_position_out) seen_inval <= 1'b1;
    if (open_cmd_out | close_cmd_out) run <= run + 1;
    else if (run != 0) last <= run;
    if (!(open_cmd_out | close_cmd_out)) run <= 0;
    if (cycles == 40000) begin
      num_errors++;
      give_verdict();
    end
  end
  task automatic ms(input int n);
    repeat (n * 10) @(posedge pclk);
  endtask : ms
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [31:0] near(input int len, input int t);
    return {31'h0, len >= t * 10 - 10 && len <= t * 10 + 10};
  endfunction : near
  function automatic logic [31:0] exp_go(input logic [31:0] v);
    return {31'h0, (v[7] ? v[0] : v[1]) & !(v[2] & v[3]) & (v[4] | v[5] | (v[6] & !v[8]))};
  endfunction : exp_go
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict
  // ****
  // Scenarios
  // ****
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, REG_PULSE + 8'(4 * i), 32'h0);
      check(rd, {16'h0, dflt[i]});
    end
    apb(1'b0, REG_CTRL, 32'h0);
    check(rd, 32'h00000004);
    apb(1'b0, 8'h30, 32'h0);
    check({31'h0, err}, 32'h00000001);
    $display("test defaults done");
    master_permit_in <= 1'b1;
    apb(1'b1, REG_PULSE, 32'h00000001);
    apb(1'b0, REG_PULSE, 32'h0);
    check(rd, {16'h0, PULSE_MIN});
    apb(1'b1, REG_CMD, 32'h00000001);
    ms(60);
    check(near(last, 50), 32'h1);
    travel <= 8'h14;
    apb(1'b1, REG_PULSE, 32'h000003E8);
    apb(1'b1, REG_CMD, 32'h00000002);
    apb(1'b1, REG_CMD, 32'h00000001);
    apb(1'b0, REG_STATUS, 32'h0);
    check({31'h0, rd[11]}, 32'h1);
    ms(110);
    check(near(last, 100), 32'h1);
    $display("test pulses done");
    for (int i = 0; i < 6; i++) begin
      r = $random(seed);
      panel_permit_in <= r[0];
      master_permit_in <= r[1];
      block_operation_in <= r[2] & r[3];
      open_interlock_permit <= r[4] | r[5];
      close_interlock_permit <= r[4] | r[5];
      apb(1'b1, REG_CTRL, {29'h0, r[8], 2'h0});
      apb(1'b1, REG_CMD, {27'h0, r[6], r[7], 1'b0, position_open_in, !position_open_in});
      ms(1);
      check({31'h0, open_cmd_out | close_cmd_out}, exp_go(r));
      ms(120);
    end
    $display("test gating done");
    master_permit_in <= 1'b1;
    block_operation_in <= 1'b0;
    open_interlock_permit <= 1'b1;
    close_interlock_permit <= 1'b1;
    synchronism_ok_in <= 1'b0;
    seen_start <= 1'b0;
    apb(1'b1, REG_CTRL, 32'h00000004);
    apb(1'b1, REG_SYNC, 32'h0000000A);
    apb(1'b1, REG_CMD, 32'h00000002);
    ms(15);
    apb(1'b0, REG_STATUS, 32'h0);
    check({30'h0, rd[5], close_cmd_out | seen_start}, 32'h0);
    apb(1'b1, REG_SWITCH, 32'h00000014);
    apb(1'b1, REG_CMD, 32'h00000002);
    ms(12);
    check({31'h0, synchro_switch_start_out}, 32'h1);
    synchro_switch_impulse_in <= 1'b1;
    ms(1);
    synchro_switch_impulse_in <= 1'b0;
    check({31'h0, close_cmd_out}, 32'h1);
    ms(110);
    synchronism_ok_in <= 1'b1;
    $display("test synchro done");
    travel <= 8'h00;
    apb(1'b1, REG_PULSE, 32'h00000032);
    apb(1'b1, REG_CTRL, 32'h00000005);
    apb(1'b1, REG_OPER, 32'h00000000);
    apb(1'b1, REG_CMD, 32'h00000001);
    ms(15);
    apb(1'b0, REG_STATUS, 32'h0);
    check({30'h0, rd[10], seen_inval}, 32'h3);
    ms(40);
    apb(1'b1, REG_CTRL, 32'h00000006);
    apb(1'b1, REG_SBO, 32'h00000000);
    apb(1'b1, REG_CMD, 32'h00000005);
    apb(1'b0, REG_STATUS, 32'h0);
    check({31'h0, rd[6]}, 32'h1);
    ms(1010);
    apb(1'b0, REG_STATUS, 32'h0);
    check({31'h0, rd[6]}, 32'h0);
    $display("test models done");
    // First move consumes the pending stuck command
    travel <= 8'h14;
    kick <= 1'b1;
    @(posedge pclk);
    kick <= 1'b0;
    ms(160);
    apb(1'b1, REG_INTER, 32'h00000014);
    apb(1'b0, REG_COUNT, 32'h0);
    c0 = rd;
    travel <= 8'hFF;
    kick <= 1'b1;
    @(posedge pclk);
    kick <= 1'b0;
    ms(24);
    check({31'h0, intermediate_out}, 32'h1);
    ms(3);
    check({30'h0, unintended_operation_out, operation_pulse_out}, 32'h3);
    check({30'h0, breaker_state_code}, {30'h0, position_closed_in, position_open_in});
    apb(1'b0, REG_COUNT, 32'h0);
    check(rd, c0 + 32'h1);
    $display("test unintended done");
    give_verdict();
  end
endmodule : breaker_command_sequencer_test
